// File: verilog/ecm_pkg.sv
`default_nettype none
package ecm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CHAN_W = 5;
	localparam int NCHAN  = 32;
	localparam logic [7:0] OFS_SEND_OUT_LEVEL    = 8'h1F;
	localparam logic [7:0] OFS_RECV_IN_LEVEL     = 8'h20;
	localparam logic [7:0] OFS_SEND_IN_OFFSET    = 8'h21;
	localparam logic [7:0] OFS_SEND_OUT_OFFSET   = 8'h22;
	localparam logic [7:0] OFS_ART_ECHO_LEVEL    = 8'h23;
	localparam logic [7:0] OFS_NOISE_LEVEL       = 8'h24;
	localparam logic [7:0] OFS_ECHO_RET_LOSS     = 8'h25;
	localparam logic [7:0] OFS_COMBINED_LOSS     = 8'h26;
	localparam logic [7:0] OFS_SUPP_THRESH       = 8'h27;
	localparam logic [7:0] OFS_OVERCOMP_HANGOVER = 8'h28;
	localparam logic [7:0] OFS_STATE_FIRST       = 8'h2C;
	localparam logic [7:0] OFS_STATE_SECOND      = 8'h2D;
	localparam logic [7:0] OFS_STATE_THIRD       = 8'h2E;
	localparam logic [7:0] OFS_CHANNEL_CONTROL   = 8'h30;
	localparam logic [7:0] OFS_FLAG_PIN_SELECT   = 8'h31;
	localparam logic [7:0] MASK_OFFSET = 8'h3F;
	localparam logic [7:0] MASK_NOISE  = 8'h7F;
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam int         UPDATE_BIT  = 7;
	localparam logic [7:0] LOG_MAX     = 8'hBF;
	localparam logic [7:0] LOG_STEP_6DB = 8'h10;
	localparam logic [7:0] LOG_MINUS_INF = 8'h00;
	localparam int NREG = 13;
endpackage
`default_nettype wire

// File: verilog/ecm_monitor.sv
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - send output level, 8-bit log code, at 1FH
// - receive input level, 8-bit log code, at 20H
// - send input offset, 6-bit ones complement at 21H, top bits zero
// - send output offset, 6-bit ones complement at 22H, top bits zero
// - artificial echo level, 8-bit log, at 23H
// - background noise level, 7-bit log in bits 6..0 at 24H
// - echo return loss estimate, 8-bit log, at 25H
// - combined loss without suppressor, 8-bit log, at 26H
// - suppressor threshold level, 8-bit log, at 27H
// - overcompensation in bits 7..4, hang-over time in bits 3..0 at 28H
// - first state byte 2CH: no voice, three answer tone flags in bits 7..4
// - first byte bits 3..0: filter reset, frozen, suppressor active, bypass
// - second byte 2DH: bit 7 subtractor bypass, bit 6 double talk
// - second byte: bit 5 fast converge, bit 4 stability protect, bit 0 idle
// - second byte: continuity tone bit 3 unprotected, bit 1 level1, bit 2 level2
// - any second-byte bit selectable onto either of two flag output pins
// - third byte 2EH: bit 7 signalling disable, 6 user disable, 5 user fix
// - third byte bits 4..0 mirror the five serial control inputs
// - log codes: 191 is +3 dBm0, 16 per 6 dB, 0 minus infinity
// - values shown are those of the channel software selects in 5-bit field
module ecm_monitor #(
	parameter int NCHAN = ecm_pkg::NCHAN
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [ecm_pkg::ADDR_W-1:0]    wb_adr_i,
	input  wire logic [ecm_pkg::DATA_W-1:0]    wb_dat_i,
	input  wire logic                          wb_sel_i,
	output logic      [ecm_pkg::DATA_W-1:0]    wb_dat_o,
	output logic                               wb_ack_o,
	input  wire logic [NCHAN*8*ecm_pkg::NREG-1:0] mon_bus_i,
	input  wire logic                          update_pulse_i,
	output logic      [ecm_pkg::CHAN_W-1:0]    monitored_channel_select_o,
	output logic                               monitor_update_flag_o,
	output logic                               flag_output_pin_one_o,
	output logic                               flag_output_pin_two_o
);
	localparam int NREG = ecm_pkg::NREG;
	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [ecm_pkg::CHAN_W-1:0] chan_q;
	logic                       upd_q;
	logic [2:0]                 pin1_sel_q;
	logic [2:0]                 pin2_sel_q;
	logic [7:0]                 snap_q [NREG];
	logic [7:0]                 rd_d;
	logic                       ack_q;
	logic [7:0]                 dat_q;
	logic                       req;
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	////////////////////////////////////////////////////////////////////////////
	// snapshot of selected channel, masked for unused bits
	genvar g;
	generate
		for (g = 0; g < NREG; g++)
		begin : g_snap
			logic [7:0] raw;
			logic [7:0] msk;
			assign raw = mon_bus_i[(int'(chan_q)*NREG+g)*8 +: 8];
			assign msk = (g == 2 || g == 3) ? ecm_pkg::MASK_OFFSET :
				(g == 5) ? ecm_pkg::MASK_NOISE : 8'hFF;
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					snap_q[g] <= ecm_pkg::RESET_BYTE;
				else
					snap_q[g] <= raw & msk;
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			chan_q     <= '0;
			pin1_sel_q <= '0;
			pin2_sel_q <= '0;
		end
		else if (req && wb_we_i && wb_sel_i)
		begin
			if (wb_adr_i == ecm_pkg::OFS_CHANNEL_CONTROL)
				chan_q <= wb_dat_i[ecm_pkg::CHAN_W-1:0];
			if (wb_adr_i == ecm_pkg::OFS_FLAG_PIN_SELECT)
			begin
				pin1_sel_q <= wb_dat_i[2:0];
				pin2_sel_q <= wb_dat_i[6:4];
			end
		end
	end
	// update flag: set wins over clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			upd_q <= 1'b0;
		else if (update_pulse_i)
			upd_q <= 1'b1;
		else if (req && wb_we_i && wb_sel_i && wb_adr_i == ecm_pkg::OFS_CHANNEL_CONTROL
			&& !wb_dat_i[ecm_pkg::UPDATE_BIT])
			upd_q <= 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	// read decode
	always_comb
	begin
		rd_d = 8'h00;
		unique case (wb_adr_i)
			ecm_pkg::OFS_SEND_OUT_LEVEL:    rd_d = snap_q[0];
			ecm_pkg::OFS_RECV_IN_LEVEL:     rd_d = snap_q[1];
			ecm_pkg::OFS_SEND_IN_OFFSET:    rd_d = snap_q[2];
			ecm_pkg::OFS_SEND_OUT_OFFSET:   rd_d = snap_q[3];
			ecm_pkg::OFS_ART_ECHO_LEVEL:    rd_d = snap_q[4];
			ecm_pkg::OFS_NOISE_LEVEL:       rd_d = snap_q[5];
			ecm_pkg::OFS_ECHO_RET_LOSS:     rd_d = snap_q[6];
			ecm_pkg::OFS_COMBINED_LOSS:     rd_d = snap_q[7];
			ecm_pkg::OFS_SUPP_THRESH:       rd_d = snap_q[8];
			ecm_pkg::OFS_OVERCOMP_HANGOVER: rd_d = snap_q[9];
			ecm_pkg::OFS_STATE_FIRST:       rd_d = snap_q[10];
			ecm_pkg::OFS_STATE_SECOND:      rd_d = snap_q[11];
			ecm_pkg::OFS_STATE_THIRD:       rd_d = snap_q[12];
			ecm_pkg::OFS_CHANNEL_CONTROL:   rd_d = {upd_q, 2'b00, chan_q};
			ecm_pkg::OFS_FLAG_PIN_SELECT:   rd_d = {1'b0, pin2_sel_q, 1'b0, pin1_sel_q};
			default:                        rd_d = 8'h00;
		endcase
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 8'h00;
		end
		else
		begin
			ack_q <= req;
			if (req && !wb_we_i)
				dat_q <= rd_d;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign monitored_channel_select_o = chan_q;
	assign monitor_update_flag_o = upd_q;
	////////////////////////////////////////////////////////////////////////////
	// flag pins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			flag_output_pin_one_o <= 1'b0;
			flag_output_pin_two_o <= 1'b0;
		end
		else
		begin
			flag_output_pin_one_o <= snap_q[11][pin1_sel_q];
			flag_output_pin_two_o <= snap_q[11][pin2_sel_q];
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// checks
	// bus handshake
	AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	AST_ACK_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("no ack");

	// masked bits, unmapped read and ignored writes
	AST_OFFSET_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
		(snap_q[2][7:6] == 2'b00) && (snap_q[3][7:6] == 2'b00))
		else $error("offset top bits set");

	AST_NOISE_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
		!snap_q[5][7])
		else $error("noise bit 7 set");

	AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == 8'h40) |=> wb_dat_o == 8'h00)
		else $error("unmapped read nonzero");

	AST_WR_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && wb_we_i && wb_adr_i != ecm_pkg::OFS_CHANNEL_CONTROL
			&& wb_adr_i != ecm_pkg::OFS_FLAG_PIN_SELECT)
		|=> $stable(chan_q) && $stable(pin1_sel_q) && $stable(pin2_sel_q))
		else $error("monitor write changed state");

	// channel select and update flag
	AST_SEL_CHAN: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && wb_we_i && wb_sel_i && wb_adr_i == ecm_pkg::OFS_CHANNEL_CONTROL)
		|=> chan_q == $past(wb_dat_i[ecm_pkg::CHAN_W-1:0]))
		else $error("channel not taken");

	AST_UPD_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		update_pulse_i |=> monitor_update_flag_o)
		else $error("update lost");

	AST_UPD_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
		(!update_pulse_i && req && wb_we_i && wb_sel_i
			&& wb_adr_i == ecm_pkg::OFS_CHANNEL_CONTROL && !wb_dat_i[ecm_pkg::UPDATE_BIT])
		|=> !monitor_update_flag_o)
		else $error("update flag not cleared");

	// flag pins
	AST_PIN_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 flag_output_pin_one_o == $past(snap_q[11][pin1_sel_q]))
		else $error("pin one wrong");

	AST_PIN_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 flag_output_pin_two_o == $past(snap_q[11][pin2_sel_q]))
		else $error("pin two wrong");

	// read data per monitor byte
	AST_RD_SEND_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_SEND_OUT_LEVEL) |=> wb_dat_o == $past(snap_q[0]))
		else $error("send output level read wrong");

	AST_RD_RECV_IN: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_RECV_IN_LEVEL) |=> wb_dat_o == $past(snap_q[1]))
		else $error("receive input level read wrong");

	AST_RD_IN_OFS: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_SEND_IN_OFFSET) |=> wb_dat_o == $past(snap_q[2]))
		else $error("send input offset read wrong");

	AST_RD_OUT_OFS: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_SEND_OUT_OFFSET) |=> wb_dat_o == $past(snap_q[3]))
		else $error("send output offset read wrong");

	AST_RD_ART_ECHO: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_ART_ECHO_LEVEL) |=> wb_dat_o == $past(snap_q[4]))
		else $error("artificial echo read wrong");

	AST_RD_NOISE: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_NOISE_LEVEL) |=> wb_dat_o == $past(snap_q[5]))
		else $error("noise level read wrong");

	AST_ERL_READ: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_ECHO_RET_LOSS) |=> wb_dat_o == $past(snap_q[6]))
		else $error("loss read wrong");

	AST_RD_COMBINED: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_COMBINED_LOSS) |=> wb_dat_o == $past(snap_q[7]))
		else $error("combined loss read wrong");

	AST_RD_THRESH: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_SUPP_THRESH) |=> wb_dat_o == $past(snap_q[8]))
		else $error("threshold read wrong");

	AST_RD_OVERCOMP: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_OVERCOMP_HANGOVER) |=> wb_dat_o == $past(snap_q[9]))
		else $error("overcomp read wrong");

	AST_RD_STATE1: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_STATE_FIRST) |=> wb_dat_o == $past(snap_q[10]))
		else $error("first state byte read wrong");

	AST_RD_STATE2: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_STATE_SECOND) |=> wb_dat_o == $past(snap_q[11]))
		else $error("second state byte read wrong");

	AST_RD_STATE3: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == ecm_pkg::OFS_STATE_THIRD) |=> wb_dat_o == $past(snap_q[12]))
		else $error("third state byte read wrong");
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                 clk_i      = 1'b0;
	logic                 rst_i      = 1'b1;
	logic                 req        = 1'b0;
	logic                 we         = 1'b0;
	logic                 upd        = 1'b0;
	logic [7:0]           adr        = 8'h00;
	logic [7:0]           dat        = 8'h00;
	logic [7:0]           q;
	logic [7:0]           rd;
	logic [7:0]           b;
	logic                 ack;
	logic                 pin1;
	logic                 pin2;
	logic                 flag;
	logic [4:0]           chs;
	logic [32*8*13-1:0]   mon;
	int                   num_errors = 0;
	int                   checked    = 0;
	int                   ch [2]     = '{5, 31};

	ecm_monitor #(.NCHAN(32)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(1'b1), .wb_dat_o(rd), .wb_ack_o(ack), .mon_bus_i(mon),
		.update_pulse_i(upd), .monitored_channel_select_o(chs), .monitor_update_flag_o(flag),
		.flag_output_pin_one_o(pin1), .flag_output_pin_two_o(pin2));

	always #12.5 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] raw(input int c, input int k);
		return 8'((c * 13 + k) * 29 + 90) | ((k == 2 || k == 3 || k == 5) ? 8'hC0 : 8'h00);
	endfunction

	function automatic logic [7:0] msk(input int k);
		return (k == 2 || k == 3) ? 8'h3F : (k == 5) ? 8'h7F : 8'hFF;
	endfunction

	task complete_run;
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task cmp(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one classic cycle, entered just after a rising edge
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		req <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rd;
		req <= 1'b0;
		if (n >= 20)
			num_errors++;
		@(posedge clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3000) @(posedge clk_i);
		num_errors++;
		complete_run;
	end

	initial
	begin
		for (int c = 0; c < 32; c++)
			for (int k = 0; k < 13; k++)
				mon[(c * 13 + k) * 8 +: 8] = raw(c, k);
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		cmp({3'h0, chs}, 8'h00);
		foreach (ch[i])
		begin
			wb(1'b1, 8'h30, 8'(ch[i]));
			repeat (2) @(posedge clk_i);
			cmp({3'h0, chs}, 8'(ch[i]));
			for (int k = 0; k < 13; k++)
			begin
				wb(1'b1, 8'(k < 10 ? 31 + k : 34 + k), 8'hFF);
				wb(1'b0, 8'(k < 10 ? 31 + k : 34 + k), 8'h00);
				cmp(q, raw(ch[i], k) & msk(k));
			end
		end
		wb(1'b0, 8'h40, 8'h00);
		cmp(q, 8'h00);
		// flag pins follow the selected bit of channel 31
		b = raw(31, 11);
		for (int i = 0; i < 8; i++)
		begin
			wb(1'b1, 8'h31, 8'(((7 - i) << 4) | i));
			repeat (3) @(posedge clk_i);
			cmp({7'h0, pin1}, {7'h0, b[i]});
			cmp({7'h0, pin2}, {7'h0, b[7 - i]});
		end
		upd <= 1'b1;
		@(posedge clk_i);
		upd <= 1'b0;
		@(posedge clk_i);
		cmp({7'h0, flag}, 8'h01);
		wb(1'b0, 8'h30, 8'h00);
		cmp(q, 8'h9F);
		// update pulse on the edge that takes a clear: set wins
		fork
			wb(1'b1, 8'h30, 8'h1F);
			begin
				upd <= 1'b1;
				@(posedge clk_i);
				upd <= 1'b0;
			end
		join
		cmp({7'h0, flag}, 8'h01);
		wb(1'b1, 8'h30, 8'h1F);
		@(posedge clk_i);
		cmp({7'h0, flag}, 8'h00);
		complete_run;
	end
endmodule
`default_nettype wire
